// ==== rtl/power_mode_wakeup_control.sv ====
// Power mode selection, wake-up source flags and power unit mode register on the SFR port.
`timescale 1ns/1ps
`default_nettype none
module power_mode_wakeup_control (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire power_unit_pkg::sfr_request_type sfr_req,
    output logic [7:0]                           sfr_rdata,
    output logic                                 sfr_hit,
    input  wire power_unit_pkg::wake_event_type  wake_pins,
    input  wire logic                            reset_pin_n,
    input  wire logic                            reset_source_event,
    output logic                                 sleep_active,
    output logic                                 suspend_active,
    output logic                                 stop_request,
    output logic                                 idle_request,
    output logic                                 low_power_osc_keep,
    output logic                                 buffered_clock_out_enable,
    output logic                                 wake_request_out,
    output logic                                 wake_request_out_enable,
    output logic                                 battery_monitor_disable,
    output logic                                 full_por_request
);
    localparam int n = power_unit_pkg::source_count;

    // Event pins are asynchronous; reset pin rides along as the top bit
    logic [n:0] sync_level;
    logic [n:0] sync_rise;
    logic [n:0] sync_fall;

    pin_edge_sync #(
        .width (n + 1)
    ) u_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   ({reset_pin_n, wake_pins}),
        .level (sync_level),
        .rise  (sync_rise),
        .fall  (sync_fall)
    );

    logic [n-1:0] source_event;
    logic         reset_pin_fall;

    // Failure and alarm are levels; match is taken as its rising edge too
    assign source_event   = {sync_level[3], sync_level[2], sync_rise[1], sync_rise[0]};
    assign reset_pin_fall = sync_fall[n];

    function automatic logic reg_sel(input power_unit_pkg::sfr_request_type r,
                                     input logic [7:0] a, input logic [3:0] p,
                                     input logic any_page);
        reg_sel = (r.addr == a) && (any_page || (r.page == p));
    endfunction

    logic sel_config;
    logic sel_mode;
    logic sel_control;
    logic wr_config;
    logic wr_mode;
    logic wr_control;

    assign sel_config  = reg_sel(sfr_req, power_unit_pkg::wake_configuration_addr,
                                 power_unit_pkg::wake_configuration_page, 1'b0);
    assign sel_mode    = reg_sel(sfr_req, power_unit_pkg::power_unit_mode_addr,
                                 power_unit_pkg::power_unit_mode_page, 1'b0);
    assign sel_control = reg_sel(sfr_req, power_unit_pkg::power_control_addr,
                                 4'h0, 1'b1);
    assign wr_config   = sfr_req.wr & sel_config;
    assign wr_mode     = sfr_req.wr & sel_mode;
    assign wr_control  = sfr_req.wr & sel_control;

    // State
    power_unit_pkg::power_state_type state;
    power_unit_pkg::power_state_type next_state;
    logic [n-1:0] entry_enable;
    logic [n-1:0] next_entry_enable;
    logic [n:0]   flags;
    logic [n:0]   next_flags;
    logic [1:0]   blank_count;
    logic [1:0]   next_blank_count;
    logic [2:0]   mode_bits;
    logic [2:0]   next_mode_bits;
    logic [5:0]   general_flags;
    logic [5:0]   next_general_flags;
    logic         stop_pulse;
    logic         next_stop_pulse;
    logic         idle_pulse;
    logic         next_idle_pulse;
    logic         por_pulse;
    logic         next_por_pulse;
    logic [7:0]   read_data;
    logic [7:0]   next_read_data;

    logic [n:0] cleared_flags;
    logic       wake_now;

    always_comb begin
        next_state         = state;
        next_entry_enable  = entry_enable;
        next_mode_bits     = mode_bits;
        next_general_flags = general_flags;
        next_stop_pulse    = 1'b0;
        next_idle_pulse    = 1'b0;
        next_por_pulse     = 1'b0;
        next_blank_count   = (blank_count != 2'h0) ? blank_count - 2'h1 : 2'h0;

        // Clear first, then events, so an event in the clearing cycle survives
        cleared_flags = flags;
        if (wr_config && sfr_req.wdata[power_unit_pkg::clear_bit]) begin
            cleared_flags = power_unit_pkg::flags_reset;
        end
        next_flags = cleared_flags;
        next_flags[n-1:0] = cleared_flags[n-1:0] | source_event;
        next_flags[n] = cleared_flags[n] | reset_pin_fall;

        wake_now = (|(flags[n-1:0] & entry_enable)) | reset_pin_fall;

        if (wr_config) begin
            // Entry is refused while any flag stands, including one raised now
            if (state == power_unit_pkg::mode_awake && next_flags == '0) begin
                if (sfr_req.wdata[power_unit_pkg::sleep_bit]) begin
                    next_state        = power_unit_pkg::mode_sleep;
                    next_entry_enable = sfr_req.wdata[n-1:0];
                end else if (sfr_req.wdata[power_unit_pkg::suspend_bit]) begin
                    next_state        = power_unit_pkg::mode_suspend;
                    next_entry_enable = sfr_req.wdata[n-1:0];
                end
            end
        end

        unique case (state)
            power_unit_pkg::mode_awake: begin
            end
            power_unit_pkg::mode_sleep: begin
                if (wake_now) begin
                    next_state = power_unit_pkg::mode_awake;
                end
            end
            power_unit_pkg::mode_suspend: begin
                if (wake_now) begin
                    next_state       = power_unit_pkg::mode_awake;
                    next_blank_count = power_unit_pkg::suspend_blank_cycles;
                end
            end
        endcase

        if (wr_mode) begin
            next_mode_bits = sfr_req.wdata[7:5];
        end
        if (wr_control) begin
            next_general_flags = sfr_req.wdata[7:power_unit_pkg::general_flags_lsb];
            next_stop_pulse    = sfr_req.wdata[power_unit_pkg::stop_bit];
            next_idle_pulse    = sfr_req.wdata[power_unit_pkg::idle_bit];
        end

        // Monitor off turns any reset source into a full power-on reset
        if (reset_source_event && mode_bits[0]) begin
            next_por_pulse = 1'b1;
        end

        next_read_data = 8'h00;
        if (sfr_req.rd) begin
            if (sel_config) begin
                // Write-only bits read zero; flags blanked just after suspend
                next_read_data = (blank_count != 2'h0) ? 8'h00 : {3'h0, flags};
            end else if (sel_mode) begin
                next_read_data = {mode_bits, power_unit_pkg::mode_unused_value};
            end else if (sel_control) begin
                next_read_data = {general_flags, 2'h0};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state         <= power_unit_pkg::mode_awake;
            entry_enable  <= power_unit_pkg::enable_reset;
            flags         <= power_unit_pkg::flags_reset;
            blank_count   <= 2'h0;
            mode_bits     <= power_unit_pkg::power_unit_mode_reset[7:5];
            general_flags <= power_unit_pkg::power_control_reset[7:2];
            stop_pulse    <= 1'b0;
            idle_pulse    <= 1'b0;
            por_pulse     <= 1'b0;
            read_data     <= 8'h00;
        end else begin
            state         <= next_state;
            entry_enable  <= next_entry_enable;
            flags         <= next_flags;
            blank_count   <= next_blank_count;
            mode_bits     <= next_mode_bits;
            general_flags <= next_general_flags;
            stop_pulse    <= next_stop_pulse;
            idle_pulse    <= next_idle_pulse;
            por_pulse     <= next_por_pulse;
            read_data     <= next_read_data;
        end
    end

    assign sfr_rdata                 = read_data;
    assign sfr_hit                   = sel_config | sel_mode | sel_control;
    assign sleep_active              = (state == power_unit_pkg::mode_sleep);
    assign suspend_active            = (state == power_unit_pkg::mode_suspend);
    assign stop_request              = stop_pulse;
    assign idle_request              = idle_pulse;
    assign low_power_osc_keep        = |flags;
    assign buffered_clock_out_enable = mode_bits[2];
    assign wake_request_out          = (state != power_unit_pkg::mode_sleep);
    assign wake_request_out_enable   = mode_bits[1];
    assign battery_monitor_disable   = mode_bits[0];
    assign full_por_request          = por_pulse;
endmodule
`default_nettype wire

// ==== include/power_unit_pkg.sv ====
// Constants, register map and carrier types for the power mode and wake-up control unit.
// Contract
// - Sleep bit write of one enters sleep
// - Suspend bit write of one enters suspend
// - Clear bit write of one clears flags
// - Bit 4 flags reset pin falling edge
// - Bit 3 enables/flags oscillator failure
// - Bit 2 enables/flags clock alarm
// - Bit 1 enables/flags port match
// - Bit 0 enables/flags comparator rising edge
// - Any set flag blocks entry, keeps oscillator
// - Flags read zero two clocks after suspend
// - Mode bit 7 enables buffered clock output
// - Mode bit 6 drives wake request pin
// - Mode bit 5 disables battery monitor
// - Mode bits 4:0 read zero, ignore writes
// - Control bits 7:2 are general flags
// - Control bit 1 write enters stop
// - Control bit 0 write enters idle
// - Wake request high awake, low asleep
// - Flags update regardless of enables
// - Monitor disabled: resets become full power-on
// - Reset pin always wakes the device
package power_unit_pkg;

    localparam logic [7:0] power_control_addr      = 8'h87;
    localparam logic [7:0] wake_configuration_addr = 8'hb5;
    localparam logic [7:0] power_unit_mode_addr    = 8'hb5;
    localparam logic [3:0] wake_configuration_page = 4'h0;
    localparam logic [3:0] power_unit_mode_page    = 4'hf;

    // wake_configuration fields
    localparam int sleep_bit          = 7;
    localparam int suspend_bit        = 6;
    localparam int clear_bit          = 5;
    localparam int reset_pin_flag_bit = 4;
    localparam int clock_osc_fail_bit = 3;
    localparam int clock_alarm_bit    = 2;
    localparam int port_match_bit     = 1;
    localparam int comparator_bit     = 0;
    localparam int source_count       = 4;

    // power_unit_mode fields
    localparam int buffered_clock_out_bit = 7;
    localparam int wake_request_out_bit   = 6;
    localparam int battery_monitor_bit    = 5;
    localparam logic [4:0] mode_unused_value = 5'h00;

    // power_control fields
    localparam int general_flags_lsb = 2;
    localparam int stop_bit          = 1;
    localparam int idle_bit          = 0;

    localparam logic [7:0] power_control_reset   = 8'h00;
    localparam logic [7:0] power_unit_mode_reset = 8'h00;
    localparam logic [3:0] enable_reset          = 4'h0;
    localparam logic [4:0] flags_reset           = 5'h00;

    // Clocks during which flags read zero after suspend
    localparam logic [1:0] suspend_blank_cycles = 2'h2;

    typedef enum logic [1:0] {
        mode_awake,
        mode_sleep,
        mode_suspend
    } power_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] page;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_request_type;

    typedef struct packed {
        logic clock_osc_fail;
        logic clock_alarm;
        logic port_match;
        logic comparator_zero;
    } wake_event_type;

endpackage

// ==== rtl/pin_edge_sync.sv ====
// Two-stage synchroniser with rise and fall pulse detection for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
    parameter int width = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [width-1:0] pin,
    output logic      [width-1:0] level,
    output logic      [width-1:0] rise,
    output logic      [width-1:0] fall
);
    logic [width-1:0] stage1;
    logic [width-1:0] stage2;
    logic [width-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < width; i++) begin : g_bit
            // Stage1 feeds only stage2; edges are judged from the settled stages
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                end else begin
                    stage1[i] <= pin[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                end
            end
            assign level[i] = stage2[i];
            assign rise[i]  = stage2[i] & ~stage3[i];
            assign fall[i]  = ~stage2[i] & stage3[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ==== bench/power_mode_wakeup_control_sva.sv ====
// Port checker for the power mode and wake-up control unit, bound to its top.
`timescale 1ns/1ps
`default_nettype none
module power_mode_wakeup_control_sva (
    input wire logic                            mclk,
    input wire logic                            rst,
    input wire power_unit_pkg::sfr_request_type sfr_req,
    input wire logic [7:0]                      sfr_rdata,
    input wire logic                            sfr_hit,
    input wire power_unit_pkg::wake_event_type  wake_pins,
    input wire logic                            reset_pin_n,
    input wire logic                            reset_source_event,
    input wire logic                            sleep_active,
    input wire logic                            suspend_active,
    input wire logic                            stop_request,
    input wire logic                            idle_request,
    input wire logic                            low_power_osc_keep,
    input wire logic                            buffered_clock_out_enable,
    input wire logic                            wake_request_out,
    input wire logic                            wake_request_out_enable,
    input wire logic                            battery_monitor_disable,
    input wire logic                            full_por_request
);
    logic mode_sel;
    logic cfg_sel;
    logic pc_wr;
    logic entry_wr;
    assign mode_sel = sfr_req.addr == 8'hb5 && sfr_req.page == 4'hf;
    assign cfg_sel  = sfr_req.addr == 8'hb5 && sfr_req.page == 4'h0;
    assign pc_wr    = sfr_req.wr && sfr_req.addr == 8'h87;
    // Clear bit excluded: a clear in the same write may legally let entry through
    assign entry_wr = sfr_req.wr && cfg_sel && sfr_req.wdata[7] && !sfr_req.wdata[5];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_wake_req_level: assert property (wake_request_out == !sleep_active)
        else $error("wake request level disagrees with sleep state");
    a_mode_unused_zero: assert property (
        sfr_req.rd && mode_sel |=> sfr_rdata[4:0] == 5'h00)
        else $error("mode register low bits not zero");
    a_mode_read_back: assert property (
        sfr_req.rd && mode_sel |=> sfr_rdata[7:5] ==
        $past({buffered_clock_out_enable, wake_request_out_enable, battery_monitor_disable}))
        else $error("mode register read disagrees with its outputs");
    a_read_data_quiet: assert property (!(sfr_req.rd && sfr_hit) |=> sfr_rdata == 8'h00)
        else $error("read data not zero without a mapped read");
    a_stop_pulse: assert property (
        stop_request == $past(pc_wr && sfr_req.wdata[1]))
        else $error("stop request does not follow control write");
    a_idle_pulse: assert property (
        idle_request == $past(pc_wr && sfr_req.wdata[0]))
        else $error("idle request does not follow control write");
    a_entry_refused: assert property (
        entry_wr && low_power_osc_keep && !sleep_active && !suspend_active |=> !sleep_active)
        else $error("sleep entered while a wake flag was set");
    a_por_pulse: assert property
        (full_por_request == $past(reset_source_event && battery_monitor_disable))
        else $error("full reset request wrong");
    a_wake_oe_by_write: assert property ($changed(wake_request_out_enable) |->
        $past(sfr_req.wr && mode_sel))
        else $error("wake request drive enable changed without a write");
    a_sleep_by_write: assert property ($rose(sleep_active) |->
        $past(sfr_req.wr && cfg_sel && sfr_req.wdata[7]))
        else $error("sleep entered without a sleep write");
    a_suspend_by_write: assert property ($rose(suspend_active) |->
        $past(sfr_req.wr && cfg_sel && sfr_req.wdata[6]))
        else $error("suspend entered without a suspend write");
    a_blank_first: assert property ($fell(suspend_active)
        && sfr_req.rd && cfg_sel |=> sfr_rdata == 8'h00)
        else $error("wake flags not blanked in first clock after suspend");
    a_blank_second: assert property ($fell(suspend_active)
        ##1 (sfr_req.rd && cfg_sel) |=> sfr_rdata == 8'h00)
        else $error("wake flags not blanked in second clock after suspend");
endmodule
bind power_mode_wakeup_control power_mode_wakeup_control_sva sva (.*);
`default_nettype wire

// ==== bench/power_mode_wakeup_control_tb_top.sv ====
// Self-checking bench for the power mode and wake-up control unit.
`timescale 1ns/1ps
`default_nettype none
module power_mode_wakeup_control_tb_top;
    logic                            mclk, rst, sfr_hit, reset_pin_n, reset_source_event;
    power_unit_pkg::sfr_request_type sfr_req;
    logic [7:0]                      sfr_rdata, seen;
    power_unit_pkg::wake_event_type  wake_pins;
    logic                            sleep_active, suspend_active, stop_request, idle_request;
    logic                            low_power_osc_keep, buffered_clock_out_enable;
    logic                            wake_request_out, wake_request_out_enable;
    logic                            battery_monitor_disable, full_por_request, hit;
    int                              miscompares, n_checks, k;

    power_mode_wakeup_control dut (.*);

    always #2.5 mclk = ~mclk;

    task automatic tally_and_finish;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    // Request is held for exactly one taking edge; answer sampled just after it
    task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] p,
                       input logic [7:0] d);
        @(posedge mclk);
        sfr_req <= {a, p, wr, !wr, d};
        @(posedge mclk);
        hit = sfr_hit;
        sfr_req <= '0;
        #1;
        seen = sfr_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [3:0] p, input logic [7:0] exp);
        acc(1'b0, a, p, 8'h00);
        check(seen, exp);
    endtask

    task automatic pin_pulse(input int idx);
        @(posedge mclk);
        wake_pins[idx] <= 1'b1;
        repeat (4) @(posedge mclk);
        wake_pins[idx] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic pin_fall;
        @(posedge mclk);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge mclk);
        reset_pin_n <= 1'b1;
    endtask

    task automatic wait_state(input logic susp, input logic val);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            #1;
            if ((susp ? suspend_active : sleep_active) === val) return;
        end
        check(!val, val);
        tally_and_finish();
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        sfr_req = '0;
        wake_pins = '0;
        reset_pin_n = 1'b1;
        reset_source_event = 1'b0;
        miscompares = 0;
        n_checks = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(8'h87, 4'h0, 8'h00);
        check(hit, 8'h01);
        rd_chk(8'hb5, 4'hf, 8'h00);
        check(hit, 8'h01);
        rd_chk(8'hb5, 4'h0, 8'h00);
        rd_chk(8'h10, 4'h0, 8'h00);
        check(hit, 8'h00);
        rd_chk(8'hb5, 4'h3, 8'h00);
        check(hit, 8'h00);
        acc(1'b1, 8'h87, 4'h3, 8'hab);
        check({stop_request, idle_request}, 8'h03);
        rd_chk(8'h87, 4'h7, 8'ha8);
        acc(1'b1, 8'h87, 4'h0, 8'h55);
        check({stop_request, idle_request}, 8'h01);
        rd_chk(8'h87, 4'h0, 8'h54);
        acc(1'b1, 8'hb5, 4'hf, 8'hff);
        check({buffered_clock_out_enable, wake_request_out_enable, battery_monitor_disable},
              8'h07);
        rd_chk(8'hb5, 4'hf, 8'he0);
        rd_chk(8'hb5, 4'h0, 8'h00);
        // The requested power-on reset is stood in for by a reset pulse mid-run
        for (k = 0; k < 2; k++) begin
            @(posedge mclk);
            reset_source_event <= 1'b1;
            @(posedge mclk);
            reset_source_event <= 1'b0;
            #1;
            check(full_por_request, k == 0);
            @(posedge mclk);
            rst <= 1'b1;
            repeat (2) @(posedge mclk);
            rst <= 1'b0;
            #1;
            check({battery_monitor_disable, wake_request_out}, 8'h01);
        end
        rd_chk(8'hb5, 4'hf, 8'h00);
        // Every source raises its flag with no enable set
        for (k = 0; k < 4; k++) begin
            pin_pulse(k);
            rd_chk(8'hb5, 4'h0, 8'h01 << k);
            check(low_power_osc_keep, 8'h01);
            acc(1'b1, 8'hb5, 4'h0, 8'h20);
            rd_chk(8'hb5, 4'h0, 8'h00);
        end
        pin_fall();
        rd_chk(8'hb5, 4'h0, 8'h10);
        acc(1'b1, 8'hb5, 4'h0, 8'h84);
        check(sleep_active, 8'h00);
        acc(1'b1, 8'hb5, 4'h0, 8'h20);
        acc(1'b1, 8'hb5, 4'h0, 8'h84);
        check({sleep_active, wake_request_out}, 8'h02);
        pin_pulse(2);
        wait_state(1'b0, 1'b0);
        check(wake_request_out, 8'h01);
        rd_chk(8'hb5, 4'h0, 8'h04);
        acc(1'b1, 8'hb5, 4'h0, 8'h20);
        acc(1'b1, 8'hb5, 4'h0, 8'h80);
        pin_pulse(1);
        check(sleep_active, 8'h01);
        pin_fall();
        wait_state(1'b0, 1'b0);
        rd_chk(8'hb5, 4'h0, 8'h12);
        acc(1'b1, 8'hb5, 4'h0, 8'h20);
        acc(1'b1, 8'hb5, 4'h0, 8'h41);
        check(suspend_active, 8'h01);
        // A read is held across the wake: two blanked clocks, then the flag shows
        @(posedge mclk);
        sfr_req <= {8'hb5, 4'h0, 1'b0, 1'b1, 8'h00};
        wake_pins[0] <= 1'b1;
        wait_state(1'b1, 1'b0);
        for (k = 0; k < 3; k++) begin
            @(posedge mclk);
            if (k == 2) begin
                sfr_req <= '0;
                wake_pins <= '0;
            end
            #1;
            check(sfr_rdata, (k == 2) ? 8'h01 : 8'h00);
        end
        repeat (3) @(posedge mclk);
        rd_chk(8'hb5, 4'h0, 8'h01);
        acc(1'b1, 8'hb5, 4'h0, 8'h20);
        tally_and_finish();
    end
endmodule
`default_nettype wire
